// [verilog/trip_pkg.sv]
// Constants, register map and carrier types for the inverter trip and reset control.
// Assumes a 50 MHz clk_sys and an AHB-Lite master with single word transfers.
package trip_pkg;

  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] OFF_DELAY_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;

  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] OFF_DELAY_RESET = 32'h0000_0000;

  // Timing, in milliseconds, and the cycle count of one millisecond.
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int RESET_MIN_MS = 12;
  localparam int ALARM_CLEAR_MAX_MS = 30;
  localparam int STUCK_RESET_MS = 4000;
  localparam int OUT_HOLD_MS = 1000;
  localparam int KEY_WINDOW_MS = 3000;
  localparam int MS_CNT_W = 13;

  // Trip codes.
  localparam logic [7:0] THERMAL_TRIP_CODE = 8'h23;
  localparam logic [7:0] THERM_OPEN_CODE = 8'h24;
  localparam logic [7:0] NO_TRIP_CODE = 8'h00;

  localparam int NUM_TERM = 6;
  localparam int NUM_LOGIC_OUT = 3;
  localparam logic [2:0] THERM_TERM = 3'h6;

  // Control register layout, high bits first.
  typedef struct packed {
    logic [21:0] unused;
    logic input_six_function_select;
    logic [5:0] closed_polarity;
    logic [2:0] reset_terminal;
  } ctrl_s;

  // Off-delay register layout; a nonzero field only selects the fixed one-second hold.
  typedef struct packed {
    logic [7:0] unused;
    logic [7:0] third_output_off_delay;
    logic [7:0] second_output_off_delay;
    logic [7:0] first_output_off_delay;
  } off_delay_s;

  // Status register layout.
  typedef struct packed {
    logic [12:0] unused;
    logic [2:0] logic_out;
    logic [7:0] trip_code;
    logic [2:0] zero;
    logic motor_on;
    logic reset_active;
    logic comm_error;
    logic alarm;
    logic trip;
  } status_s;

endpackage

// [verilog/ms_width_timer.sv]
// Millisecond width timer for one synchronised level.
// Assumes ms_tick is a one-cycle pulse once per millisecond from the same clock.
`timescale 1ns/1ns
module ms_width_timer
  import trip_pkg::*;
#(
  parameter int CNT_W = MS_CNT_W
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic ms_tick,
  input wire logic level,
  input wire logic [CNT_W-1:0] min_ms,
  output logic width_met,
  output logic released_ok,
  output logic [CNT_W-1:0] active_ms
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic level_q;
  logic cnt_full;

  // The count saturates so a stuck input never wraps back under the limit.
  assign cnt_full = &cnt_q;
  assign cnt_d = !level ? '0 : (ms_tick && !cnt_full) ? cnt_q + 1'b1 : cnt_q;
  assign width_met = level && (cnt_q >= min_ms);
  assign released_ok = level_q && !level && (cnt_q >= min_ms);
  assign active_ms = cnt_q;

  // Width counter, in whole milliseconds of the level being high.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q <= cnt_d;
      level_q <= level;
    end
  end

endmodule // ms_width_timer

// [verilog/trip_reset_ctrl.sv]
// Trip and reset control: reset contact, power-up reset, stop/reset key and thermistor trip.
// Assumes synchronous inputs on clk_sys and a single AHB-Lite master for the registers.
`timescale 1ns/1ns
module trip_reset_ctrl
  import trip_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [5:0] terminal_in,
  input wire logic thermistor_sense_input,
  input wire logic thermistor_open,
  input wire logic [3:0] operator_keys,
  input wire logic remote_operator_present,
  input wire logic run_command,
  input wire logic [2:0] logic_request,
  output logic motor_on,
  output logic coast,
  output logic [2:0] logic_out,
  output logic alarm_out,
  output logic [7:0] trip_code,
  output logic comm_error,
  output logic powerup_reset
);

  // ******************************************************
  // Bus slave
  // ******************************************************
  ctrl_s ctrl_q;
  off_delay_s delay_q;
  status_s status;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  wire addr_phase = hsel && hready && htrans[1];
  wire take_write = addr_phase && hwrite;
  wire take_read = addr_phase && !hwrite;
  wire [7:0] a_addr = haddr[7:0];
  wire a_mapped = haddr[31:8] == 24'h00_0000;
  wire [31:0] read_mux = !a_mapped ? 32'h0000_0000 :
                         (a_addr == CTRL_ADDR) ? 32'(ctrl_q) :
                         (a_addr == OFF_DELAY_ADDR) ? 32'(delay_q) :
                         (a_addr == STATUS_ADDR) ? 32'(status) : 32'h0000_0000;

  // Every transfer completes with no wait state and an OKAY answer.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Address phase capture; read data is sampled here so it leaves a flip-flop.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      wr_pend_q <= take_write && a_mapped;
      wr_addr_q <= a_addr;
      if (take_read)
      begin
        rdata_q <= read_mux;
      end
    end
  end

  // Data phase write; unmapped or read-only words ignore the data.
  wire wr_ctrl = wr_pend_q && (wr_addr_q == CTRL_ADDR);
  wire wr_delay = wr_pend_q && (wr_addr_q == OFF_DELAY_ADDR);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrl_q <= ctrl_s'(CTRL_RESET);
      delay_q <= off_delay_s'(OFF_DELAY_RESET);
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= ctrl_s'({22'h00_0000, hwdata[9:0]});
      end
      if (wr_delay)
      begin
        delay_q <= off_delay_s'({8'h00, hwdata[23:0]});
      end
    end
  end

  // ******************************************************
  // Millisecond time base
  // ******************************************************
  localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);
  logic [TICK_W-1:0] tick_cnt_q;
  wire ms_tick = tick_cnt_q == TICK_W'(MS_TICK_CYCLES - 1);

  // Free-running divider; it freezes with clk_en like everything else.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      tick_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // ******************************************************
  // Terminal decode
  // ******************************************************
  logic [5:0] polarity_eff;
  logic [5:0] term_level;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  wire therm_on = ctrl_q.input_six_function_select;

  // Each terminal may be inverted, except the one that carries the reset.
  genvar t;
  generate
    for (t = 0; t < NUM_TERM; t++)
    begin : g_term
      assign polarity_eff[t] = ctrl_q.closed_polarity[t] &&
                               (ctrl_q.reset_terminal != 3'(t + 1));
      assign term_level[t] = sync2_q[t] ^ polarity_eff[t];
    end
  endgenerate

  // Two-stage synchroniser on the contacts, so bounce near an edge is not split.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end
    else if (clk_en)
    begin
      sync1_q <= terminal_in;
      sync2_q <= sync1_q;
    end
  end

  // Terminal 6 cannot carry the reset while it is used as the thermistor input.
  wire reset_sel_ok = (ctrl_q.reset_terminal != 3'h0) &&
                      (ctrl_q.reset_terminal <= 3'(NUM_TERM)) &&
                      !(therm_on && ctrl_q.reset_terminal == THERM_TERM);
  wire [2:0] reset_idx = ctrl_q.reset_terminal - 3'h1;
  wire reset_contact_input = reset_sel_ok && term_level[reset_idx];
  wire therm_hot = therm_on && thermistor_sense_input;
  wire therm_open = therm_on && thermistor_open;

  // ******************************************************
  // Reset pulse timing
  // ******************************************************
  logic reset_width_met;
  logic reset_release_ok;
  logic [MS_CNT_W-1:0] reset_ms;

  ms_width_timer #(
    .CNT_W(MS_CNT_W)
  ) u_reset_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .ms_tick(ms_tick),
    .level(reset_contact_input),
    .min_ms(MS_CNT_W'(RESET_MIN_MS)),
    .width_met(reset_width_met),
    .released_ok(reset_release_ok),
    .active_ms(reset_ms)
  );

  // ******************************************************
  // Keys, power-up window and stuck reset
  // ******************************************************
  logic [3:0] keys_q;
  logic por_pend_q;
  logic [1:0] first_q;
  logic held_from_por_q;
  logic comm_err_q;
  logic [MS_CNT_W-1:0] up_ms_q;
  wire [3:0] key_press = operator_keys & ~keys_q;
  wire any_key = |key_press;
  wire key_window = up_ms_q < MS_CNT_W'(KEY_WINDOW_MS);
  wire key_allowed = !remote_operator_present || key_window;
  wire stuck_reset = held_from_por_q && (reset_ms > MS_CNT_W'(STUCK_RESET_MS));

  // Power-up bookkeeping; the up-time counter saturates after the key window.
  // The contact synchroniser is cleared by reset, so a contact held across power-up is
  // assumed held until the synchroniser has refilled and shows it open.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      keys_q <= 4'h0;
      por_pend_q <= 1'b1;
      first_q <= 2'b11;
      held_from_por_q <= 1'b1;
      up_ms_q <= '0;
    end
    else if (clk_en)
    begin
      keys_q <= operator_keys;
      por_pend_q <= 1'b0;
      first_q <= {first_q[0], 1'b0};
      if (ms_tick && key_window)
      begin
        up_ms_q <= up_ms_q + 1'b1;
      end
      if ((first_q == 2'b00) && !reset_contact_input)
      begin
        held_from_por_q <= 1'b0;
      end
    end
  end

  // The error shows no trip; it needs both release and a key, so setting wins.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      comm_err_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (stuck_reset)
      begin
        comm_err_q <= 1'b1;
      end
      else if (!reset_contact_input && any_key)
      begin
        comm_err_q <= 1'b0;
      end
    end
  end

  // ******************************************************
  // Trip and alarm
  // ******************************************************
  logic trip_q;
  logic [7:0] code_q;
  wire key_reset = key_press[0] && key_allowed && trip_q;
  wire reset_op = por_pend_q || reset_release_ok || key_reset;
  wire trip_clear = reset_op || reset_width_met;
  wire trip_set = therm_hot || therm_open;

  // A thermistor fault present in the clearing cycle keeps the trip set.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      trip_q <= 1'b0;
      code_q <= NO_TRIP_CODE;
    end
    else if (clk_en)
    begin
      if (trip_set && !trip_q)
      begin
        trip_q <= 1'b1;
        code_q <= therm_hot ? THERMAL_TRIP_CODE : THERM_OPEN_CODE;
      end
      else if (trip_clear && !trip_set)
      begin
        trip_q <= 1'b0;
        code_q <= NO_TRIP_CODE;
      end
    end
  end

  // ******************************************************
  // Motor and logic outputs
  // ******************************************************
  logic motor_q;
  logic coast_q;
  logic reset_q;
  logic hold_run_q;
  logic [MS_CNT_W-1:0] hold_ms_q;
  logic [2:0] hold_mask_q;
  logic [2:0] out_q;
  logic [2:0] delay_nz;
  logic [2:0] out_d;
  wire reset_onset = reset_contact_input && !reset_q;
  wire hold_done = hold_ms_q >= MS_CNT_W'(OUT_HOLD_MS);

  // Drive is allowed once the trip is gone, so a live run command restarts.
  wire motor_d = run_command && !trip_q && !trip_set && !reset_contact_input;

  // Coast is flagged when drive is cut by the reset while the motor runs.
  wire coast_d = reset_contact_input && (motor_q || coast_q);

  assign delay_nz[0] = delay_q.first_output_off_delay != 8'h00;
  assign delay_nz[1] = delay_q.second_output_off_delay != 8'h00;
  assign delay_nz[2] = delay_q.third_output_off_delay != 8'h00;

  // Per output: off at once on reset, or held for the fixed period when delayed.
  genvar o;
  generate
    for (o = 0; o < NUM_LOGIC_OUT; o++)
    begin : g_out
      assign out_d[o] = !reset_contact_input ? logic_request[o] :
                        reset_onset ? (out_q[o] && delay_nz[o]) :
                        (hold_mask_q[o] && hold_run_q && !hold_done);
    end
  endgenerate

  // Output stage and the one-second hold timer started at reset onset.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      motor_q <= 1'b0;
      coast_q <= 1'b0;
      reset_q <= 1'b0;
      hold_run_q <= 1'b0;
      hold_ms_q <= '0;
      hold_mask_q <= 3'h0;
      out_q <= 3'h0;
    end
    else if (clk_en)
    begin
      motor_q <= motor_d;
      coast_q <= coast_d;
      reset_q <= reset_contact_input;
      out_q <= out_d;
      if (reset_onset)
      begin
        hold_run_q <= 1'b1;
        hold_ms_q <= '0;
        hold_mask_q <= out_q & delay_nz;
      end
      else if (!reset_contact_input || hold_done)
      begin
        hold_run_q <= 1'b0;
      end
      else if (ms_tick)
      begin
        hold_ms_q <= hold_ms_q + 1'b1;
      end
    end
  end

  // Power-up reset pulse, also raised by every accepted reset operation.
  logic por_out_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      por_out_q <= 1'b0;
    end
    else if (clk_en)
    begin
      por_out_q <= reset_op || reset_width_met;
    end
  end

  // ******************************************************
  // Status and outputs
  // ******************************************************
  assign status.unused = 13'h0000;
  assign status.logic_out = out_q;
  assign status.trip_code = code_q;
  assign status.zero = 3'h0;
  assign status.motor_on = motor_q;
  assign status.reset_active = reset_contact_input;
  assign status.comm_error = comm_err_q;
  assign status.alarm = trip_q;
  assign status.trip = trip_q;

  assign motor_on = motor_q;
  assign coast = coast_q;
  assign logic_out = out_q;
  assign alarm_out = trip_q;
  assign trip_code = code_q;
  assign comm_error = comm_err_q;
  assign powerup_reset = por_out_q;

endmodule // trip_reset_ctrl

// [tb/trip_partner.sv]
// Far-side model: reset contact, thermistor sense lines and operator keypad.
// Assumes its tasks are called just after a rising edge of clk_sys.
`timescale 1ns/1ns
module trip_partner
#(
  parameter int MS = 10
)
(
  input wire logic clk_sys,
  output logic [5:0] terminal_in,
  output logic thermistor_sense_input,
  output logic thermistor_open,
  output logic [3:0] operator_keys
);
  logic rs_q = 1'b0;
  logic over_q = 1'b0;
  logic open_q = 1'b0;
  logic key_q = 1'b0;
  logic [4:0] spare_q = 5'h0;
  // Spare terminals keep changing, so a block that reads the wrong one shows it.
  always @(posedge clk_sys) spare_q <= spare_q + 5'h1;
  // The contact is a plain closing switch, high while closed.
  assign terminal_in = {spare_q, rs_q};
  assign thermistor_sense_input = over_q;
  assign thermistor_open = open_q;
  assign operator_keys = {3'h0, key_q};
  // Whole milliseconds; the bench asks for a short width only to see it refused.
  task automatic rs_pulse(input int ms);
    rs_q <= 1'b1;
    repeat (ms * MS) @(posedge clk_sys);
    rs_q <= 1'b0;
  endtask
  task automatic rs_level(input logic v);
    rs_q <= v;
  endtask
  task automatic therm(input logic over, input logic open);
    over_q <= over;
    open_q <= open;
  endtask
  // A press is held a few cycles so it passes any input synchroniser.
  task automatic key_tap();
    key_q <= 1'b1;
    repeat (4) @(posedge clk_sys);
    key_q <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // trip_partner

// [tb/trip_reset_ctrl_props.sv]
// Checker for the trip and reset control ports, bound into trip_reset_ctrl.
// Assumes the reset contact sits on terminal 1, as the bench configures it.
`timescale 1ns/1ns
module trip_reset_ctrl_props
  import trip_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [5:0] terminal_in,
  input wire logic thermistor_sense_input,
  input wire logic thermistor_open,
  input wire logic [3:0] operator_keys,
  input wire logic remote_operator_present,
  input wire logic run_command,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic motor_on,
  input wire logic coast,
  input wire logic alarm_out,
  input wire logic [7:0] trip_code,
  input wire logic powerup_reset
);
  localparam int ALARM_LIM = ALARM_CLEAR_MAX_MS * MS_TICK_CYCLES;
  localparam int VALID = (RESET_MIN_MS + 2) * MS_TICK_CYCLES;
  localparam int SHORT = (RESET_MIN_MS - 2) * MS_TICK_CYCLES;
  logic [15:0] hold_q, hold_d, quiet_q, quiet_d;
  logic no_therm;
  // Raw contact width and key quiet time; both saturate so long holds never wrap.
  assign hold_d = !terminal_in[0] ? 16'h0 : (&hold_q ? hold_q : hold_q + 16'h1);
  assign quiet_d = operator_keys[0] ? 16'h0 : (&quiet_q ? quiet_q : quiet_q + 16'h1);
  assign no_therm = !thermistor_sense_input && !thermistor_open;
  always_ff @(posedge clk_sys)
  begin
    hold_q <= rst_b ? hold_d : 16'h0;
    quiet_q <= rst_b ? quiet_d : 16'h0;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // A valid contact pulse ends, and a run request then holds steady.
  sequence long_release;
    $fell(terminal_in[0]) && hold_q >= VALID;
  endsequence
  sequence run_after_release;
    $fell(terminal_in[0]) && !alarm_out ##0 (run_command && no_therm)[*8];
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  chk_motor_held_off: assert property (hold_q >= 6 |-> !motor_on)
    else $error("motor driven while reset contact held");
  chk_coast_cut: assert property ($rose(terminal_in[0]) && motor_on |-> ##[1:6] coast)
    else $error("running motor not left to coast");
  chk_alarm_clear: assert property (hold_q == ALARM_LIM && no_therm |-> !alarm_out)
    else $error("alarm still set late in reset");
  chk_short_keeps: assert property (
    alarm_out && hold_q < SHORT && quiet_q > 8 && !operator_keys[0] |=> alarm_out)
    else $error("alarm dropped without a valid reset");
  chk_release_pulse: assert property (long_release |-> ##[1:5] powerup_reset)
    else $error("no reset operation on release");
  chk_powerup_pulse: assert property ($rose(rst_b) |-> ##[0:2] powerup_reset)
    else $error("no reset operation at power-up");
  chk_key_reset: assert property (alarm_out && $rose(operator_keys[0])
    && !remote_operator_present && no_therm |-> ##[1:5] !alarm_out)
    else $error("key did not clear the alarm");
  chk_run_restart: assert property (run_after_release |-> motor_on)
    else $error("motor not restarted after reset");
  chk_trip_stops: assert property (alarm_out [*2] |-> !motor_on)
    else $error("motor driven while tripped");
  chk_thermal_code: assert property (
    $rose(trip_code == THERMAL_TRIP_CODE) |-> ##[0:2] (alarm_out && !motor_on))
    else $error("thermal code without trip");
endmodule // trip_reset_ctrl_props

bind trip_reset_ctrl trip_reset_ctrl_props #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .terminal_in(terminal_in),
  .thermistor_sense_input(thermistor_sense_input), .thermistor_open(thermistor_open),
  .operator_keys(operator_keys), .remote_operator_present(remote_operator_present),
  .run_command(run_command), .hreadyout(hreadyout), .hresp(hresp), .motor_on(motor_on),
  .coast(coast), .alarm_out(alarm_out), .trip_code(trip_code),
  .powerup_reset(powerup_reset));

// [tb/tb_inverter_trip_reset_control.sv]
// Self-checking bench for trip_reset_ctrl with a behavioural far side.
// Assumes the package, the design, the partner model and the checker are compiled first.
`timescale 1ns/1ns
module tb_inverter_trip_reset_control
  import trip_pkg::*;
;
  localparam int MS = 10;
  localparam int CEIL = 90000;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic remote_operator_present = 1'b0;
  logic run_command = 1'b0;
  logic [2:0] logic_request = 3'h0;
  logic hreadyout, hresp, motor_on, coast, alarm_out, comm_error, powerup_reset, seen;
  logic thermistor_sense_input, thermistor_open;
  logic [31:0] hrdata, rd, r, dly;
  logic [31:0] seed = 32'd13545;
  logic [5:0] terminal_in;
  logic [3:0] operator_keys;
  logic [2:0] logic_out;
  logic [7:0] trip_code;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #10 clk_sys = ~clk_sys;

  trip_reset_ctrl #(.MS_TICK_CYCLES(MS)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .terminal_in(terminal_in),
    .thermistor_sense_input(thermistor_sense_input), .thermistor_open(thermistor_open),
    .operator_keys(operator_keys), .remote_operator_present(remote_operator_present),
    .run_command(run_command), .logic_request(logic_request), .motor_on(motor_on),
    .coast(coast), .logic_out(logic_out), .alarm_out(alarm_out), .trip_code(trip_code),
    .comm_error(comm_error), .powerup_reset(powerup_reset));
  trip_partner #(.MS(MS)) i_partner (.clk_sys(clk_sys), .terminal_in(terminal_in),
    .thermistor_sense_input(thermistor_sense_input), .thermistor_open(thermistor_open),
    .operator_keys(operator_keys));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Only outputs with a nonzero off-delay field stay on through the hold.
  function automatic logic [2:0] held_outs(input logic [2:0] req, input logic [31:0] d);
    return req & {|d[23:16], |d[15:8], |d[7:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single word transfer; the address phase stands until hready is seen high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    rd = hrdata;
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // A hang is cut short here and reported as a failure.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == CEIL)
    begin
      n_errors++;
      end_sim();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    bus(1'b1, STATUS_ADDR, 32'hffff_ffff);
    bus(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, CTRL_RESET);
    bus(1'b0, OFF_DELAY_ADDR, 32'h0);
    chk(rd, OFF_DELAY_RESET);
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk(rd & 32'h7, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    i_partner.therm(1'b1, 1'b1);
    repeat (20) @(posedge clk_sys);
    chk(32'(alarm_out), 32'h0);
    i_partner.therm(1'b0, 1'b0);
    $display("registers and thermistor select done");
    // Thermistor on terminal 6, reset contact on terminal 1 marked normally closed.
    bus(1'b1, CTRL_ADDR, 32'h0000_0209);
    r = xs();
    run_command <= 1'b1;
    logic_request <= r[2:0];
    i_partner.therm(1'b1, 1'b0);
    repeat (10) @(posedge clk_sys);
    chk(32'(trip_code), 32'(THERMAL_TRIP_CODE));
    chk(32'(motor_on), 32'h0);
    i_partner.therm(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    i_partner.rs_pulse(RESET_MIN_MS - 4);
    repeat (10) @(posedge clk_sys);
    chk(32'(alarm_out), 32'h1);
    i_partner.rs_pulse(RESET_MIN_MS + 2);
    repeat (10) @(posedge clk_sys);
    chk(32'(alarm_out), 32'h0);
    chk(32'(motor_on), 32'h1);
    $display("thermal trip and contact reset done");
    i_partner.therm(1'b0, 1'b1);
    repeat (10) @(posedge clk_sys);
    chk(32'(trip_code), 32'(THERM_OPEN_CODE));
    i_partner.therm(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    i_partner.key_tap();
    chk(32'(alarm_out), 32'h0);
    remote_operator_present <= 1'b1;
    i_partner.therm(1'b1, 1'b0);
    repeat (10) @(posedge clk_sys);
    i_partner.therm(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    i_partner.key_tap();
    chk(32'(alarm_out), 32'h0);
    remote_operator_present <= 1'b0;
    repeat (10) @(posedge clk_sys);
    seen = 1'b0;
    fork
      i_partner.key_tap();
      repeat (8)
      begin
        @(posedge clk_sys);
        seen = seen | powerup_reset | ~motor_on;
      end
    join
    chk(32'(seen), 32'h0);
    $display("key reset done");
    r = xs();
    logic_request <= r[2:0] | 3'h1;
    repeat (5) @(posedge clk_sys);
    fork
      i_partner.rs_pulse(RESET_MIN_MS + 1);
      begin
        repeat (8) @(posedge clk_sys);
        chk(32'(motor_on), 32'h0);
        chk(32'(coast), 32'h1);
        chk(32'(logic_out), 32'h0);
      end
    join
    repeat (8) @(posedge clk_sys);
    chk(32'(motor_on), 32'h1);
    r = xs();
    dly = {8'h0, r[23:8], r[7:0] | 8'h1};
    bus(1'b1, OFF_DELAY_ADDR, dly);
    logic_request <= 3'h7;
    repeat (5) @(posedge clk_sys);
    fork
      i_partner.rs_pulse(OUT_HOLD_MS + 50);
      begin
        repeat ((OUT_HOLD_MS - 25) * MS) @(posedge clk_sys);
        chk(32'(logic_out), 32'(held_outs(3'h7, dly)));
        repeat (40 * MS) @(posedge clk_sys);
        chk(32'(logic_out), 32'h0);
      end
    join
    run_command <= 1'b0;
    $display("output cut and off-delay hold done");
    // Contact already closed across a power-up.
    i_partner.rs_level(1'b1);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat ((STUCK_RESET_MS - 50) * MS) @(posedge clk_sys);
    chk(32'(comm_error), 32'h0);
    repeat (150 * MS) @(posedge clk_sys);
    chk(32'(comm_error), 32'h1);
    chk(32'(alarm_out), 32'h0);
    i_partner.rs_level(1'b0);
    repeat (10) @(posedge clk_sys);
    chk(32'(comm_error), 32'h1);
    i_partner.key_tap();
    chk(32'(comm_error), 32'h0);
    $display("stuck contact at power-up done");
    bus(1'b1, CTRL_ADDR, 32'h0000_0209);
    remote_operator_present <= 1'b1;
    i_partner.therm(1'b1, 1'b0);
    repeat (10) @(posedge clk_sys);
    i_partner.therm(1'b0, 1'b0);
    repeat ((KEY_WINDOW_MS + 50) * MS) @(posedge clk_sys);
    i_partner.key_tap();
    chk(32'(alarm_out), 32'h1);
    $display("remote key window done");
    end_sim();
  end
endmodule // tb_inverter_trip_reset_control
